// file: inc/amcfm_pkg.sv
// constants, types and register map of the amplifier control and fault manager
package amcfm_pkg;
	// ************************************************************
	// register offsets and reset values
	// ************************************************************
	localparam logic [7:0] FLT_OFS     = 8'h02;
	localparam logic [7:0] DRES_OFS    = 8'h03;
	localparam logic [7:0] SWCTL_OFS   = 8'h0A;
	localparam logic [7:0] DIAGCTL_OFS = 8'h0B;
	localparam logic [7:0] OUTCTL_OFS  = 8'h0C;
	localparam logic [7:0] THR_OFS     = 8'h10;
	localparam logic [7:0] TSTAT_OFS   = 8'h13;
	localparam logic [7:0] THR_RST     = 8'h01;
	localparam logic [7:0] SWCTL_RST   = 8'h0D;
	localparam logic [7:0] DIAGCTL_RST = 8'h50;
	localparam logic [7:0] OUTCTL_RST  = 8'h16;
	localparam logic [7:0] THR_MASK    = 8'h9F;
	localparam logic [7:0] OUTCTL_MASK = 8'h16;
	// ************************************************************
	// field positions and codes
	// ************************************************************
	localparam int         THR_XTALK   = 2;
	localparam int         THR_PAUSE   = 3;
	localparam int         THR_STRETCH = 4;
	localparam int         THR_SLOWCM  = 7;
	localparam int         SW_PHASE    = 5;
	localparam int         SW_FOLDREP  = 7;
	localparam int         DG_CH1      = 1;
	localparam int         DG_DCSD     = 4;
	localparam int         DG_TWEET    = 5;
	localparam int         OUT_HIZ1    = 1;
	localparam int         OUT_MUTE    = 4;
	localparam int         OUT_RESET   = 7;
	localparam logic [1:0] CODE_BAD    = 2'b11;
	localparam logic [1:0] CLIP_TWEET  = 2'b00;
	localparam logic [1:0] CLIP_CLIP   = 2'b01;
	localparam logic [1:0] CLIP_THERMAL_WARN_PIN    = 2'b10;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_HZ       = 50_000_000;
	localparam int PAUSE_MS     = 20;
	localparam int PAUSE_CYC    = PAUSE_MS * (CLK_HZ / 1000);
	localparam int DIAG_US      = 1000;
	localparam int DIAG_CYC     = DIAG_US * (CLK_HZ / 1_000_000);
	localparam int OC_US        = 100;
	localparam int OC_CYC       = OC_US * (CLK_HZ / 1_000_000);
	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {ST_STANDBY, ST_HIZ, ST_MUTE, ST_PLAY} amcfm_state_t;
	typedef struct packed {
		logic       por;
		logic       uv;
		logic       ov;
		logic       thermal_warning;
		logic [1:0] ots;
		logic [1:0] fold;
		logic [1:0] clip;
		logic [1:0] cbc;
		logic [1:0] dc;
		logic [1:0] tweeter;
		logic [1:0] open;
		logic [1:0] short;
	} amcfm_sense_t;
	typedef struct packed {
		amcfm_state_t [1:0] state;
		logic [1:0]         hard_mute;
		logic               soft_mute;
		logic               slow_cm;
		logic [1:0]         dc_thresh;
		logic               xtalk;
		logic [1:0]         fs_sel;
		logic               phase_180;
		logic               diag_busy;
		logic [1:0]         diag_phase;
	} amcfm_ctl_t;
endpackage

// file: hw/amcfm_i2c_slave.sv
// byte-level two-wire serial slave with register pointer and auto-increment
`timescale 1ns/1ps
module amcfm_i2c_slave #(
	parameter logic [6:0] DEV_ADDR = 7'h6C
) (
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       enable,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_oe,
	output logic            wr_stb,
	output logic [7:0]      reg_addr,
	output logic [7:0]      wdata,
	input  wire logic [7:0] rdata
);
	typedef enum logic [2:0] {I_IDLE, I_DEV, I_REG, I_WDATA, I_RDATA} amcfm_i2c_st_t;
	amcfm_i2c_st_t st_reg;
	logic       scl_reg, sda_reg;
	logic [3:0] cnt_reg;
	logic [7:0] sh_reg, tx_reg;
	logic       wr_done_reg;
	wire        start_w = scl_in && scl_reg && sda_reg && !sda_in;
	wire        stop_w  = scl_in && scl_reg && !sda_reg && sda_in;
	wire        rise_w  = scl_in && !scl_reg;
	wire        fall_w  = !scl_in && scl_reg && (st_reg != I_IDLE);
	assign wdata = sh_reg;

	// bus sampling, kept alive while disabled so a start is not misread on wake
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
		end else begin
			scl_reg <= scl_in;
			sda_reg <= sda_in;
		end
	end

	// protocol engine; in standby it is held idle and the data line floats
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg   <= I_IDLE;
			cnt_reg  <= 4'h0;
			sh_reg   <= 8'h00;
			tx_reg   <= 8'h00;
			sda_oe   <= 1'b0;
			wr_stb   <= 1'b0;
			reg_addr <= 8'h00;
			wr_done_reg <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			if (!enable) begin
				st_reg <= I_IDLE;
				sda_oe <= 1'b0;
			end else if (start_w) begin
				st_reg  <= I_DEV;
				cnt_reg <= 4'h0;
				sda_oe  <= 1'b0;
			end else if (stop_w) begin
				st_reg <= I_IDLE;
				sda_oe <= 1'b0;
			end else if (rise_w && st_reg != I_IDLE) begin
				if (cnt_reg < 4'h8)
					sh_reg <= {sh_reg[6:0], sda_in};
				else if (st_reg == I_RDATA && sda_in)
					st_reg <= I_IDLE; // master nack ends the read
				cnt_reg <= cnt_reg + 4'h1;
			end else if (fall_w) begin
				if (cnt_reg == 4'h8) begin
					case (st_reg)
						I_DEV: begin
							sda_oe <= (sh_reg[7:1] == DEV_ADDR);
							if (sh_reg[7:1] != DEV_ADDR)
								st_reg <= I_IDLE;
							else
								st_reg <= sh_reg[0] ? I_RDATA : I_REG;
						end
						I_REG: begin
							sda_oe   <= 1'b1;
							reg_addr <= sh_reg;
							st_reg   <= I_WDATA;
						end
						I_WDATA: begin
							sda_oe      <= 1'b1;
							wr_stb      <= 1'b1;
							wr_done_reg <= 1'b1;
						end
						I_RDATA: begin
							sda_oe   <= 1'b0;
							reg_addr <= reg_addr + 8'h01;
						end
						default: sda_oe <= 1'b0;
					endcase
				end else if (cnt_reg == 4'h9) begin
					cnt_reg <= 4'h0;
					if (st_reg == I_RDATA) begin
						tx_reg <= rdata;
						sda_oe <= ~rdata[7];
					end else begin
						sda_oe <= 1'b0;
					end
					// step only after a data byte, so the offset byte lands where it points
					if (wr_done_reg)
						reg_addr <= reg_addr + 8'h01;
					wr_done_reg <= 1'b0;
				end else if (st_reg == I_RDATA) begin
					sda_oe <= ~tx_reg[6];
					tx_reg <= {tx_reg[6:0], 1'b0};
				end
			end
		end
	end
endmodule // amcfm_i2c_slave

// file: hw/amcfm_diag_seq.sv
// load-diagnostic phase sequencer: ground short, supply short, open/short, tweeter
`timescale 1ns/1ps
module amcfm_diag_seq #(
	parameter int PHASE_CYC = 50000,
	parameter int PAUSE_CYC = 1000000
) (
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       run,
	input  wire logic       stretch,
	input  wire logic       pause_en,
	output logic            busy,
	output logic [1:0]      phase
);
	typedef enum logic [1:0] {D_IDLE, D_RUN, D_GAP, D_DONE} amcfm_diag_st_t;
	amcfm_diag_st_t st_reg;
	logic [31:0]    cnt_reg;
	// the two short phases come first and are the ones that stretch
	wire  [31:0]    len_w   = (stretch && !phase[1]) ? 32'(4 * PHASE_CYC - 1) : 32'(PHASE_CYC - 1);
	wire            last_w  = (cnt_reg == len_w);
	wire            gapend_w = (cnt_reg == 32'(PAUSE_CYC - 1));
	assign busy = (st_reg == D_RUN) || (st_reg == D_GAP);

	// sequence runs once per enable; drop the enable to rerun
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg  <= D_IDLE;
			cnt_reg <= 32'd0;
			phase   <= 2'd0;
		end else if (!run) begin
			st_reg  <= D_IDLE;
			cnt_reg <= 32'd0;
			phase   <= 2'd0;
		end else begin
			cnt_reg <= cnt_reg + 32'd1;
			case (st_reg)
				D_IDLE: begin
					st_reg  <= D_RUN;
					cnt_reg <= 32'd0;
				end
				D_RUN: if (last_w) begin
					cnt_reg <= 32'd0;
					if (phase == 2'd3)
						st_reg <= D_DONE;
					else if (pause_en)
						st_reg <= D_GAP;
					else
						phase <= phase + 2'd1;
				end
				D_GAP: if (gapend_w) begin
					cnt_reg <= 32'd0;
					phase   <= phase + 2'd1;
					st_reg  <= D_RUN;
				end
				default: cnt_reg <= 32'd0;
			endcase
		end
	end

	// the pause lasts past its first cycle before the next phase can start
	gap_length_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(st_reg == D_GAP && cnt_reg == 32'd0 && run) |=> (st_reg == D_GAP || !run))
		else $error("diag pause ended early");
endmodule // amcfm_diag_seq

// file: hw/amcfm_fault_mgr.sv
// control registers, status, fault latching and operating state of the two channels
`timescale 1ns/1ps
module amcfm_fault_mgr #(
	parameter logic [6:0] DEV_ADDR   = 7'h6C, // arbitrary bus address
	parameter int         PAUSE_CYCS = amcfm_pkg::PAUSE_CYC,
	parameter int         DIAG_CYCS  = amcfm_pkg::DIAG_CYC,
	parameter int         OC_CYCS    = amcfm_pkg::OC_CYC
) (
	input  wire logic                    ref_clk,
	input  wire logic                    rstn,
	input  wire logic                    standby_n,
	input  wire logic                    mute_n,
	input  wire logic                    scl_in,
	input  wire logic                    sda_in,
	output logic                         sda_oe,
	input  wire amcfm_pkg::amcfm_sense_t sense,
	output amcfm_pkg::amcfm_ctl_t        ctl,
	output logic                         fault_oe,
	output logic                         clip_warn_oe
);
	import amcfm_pkg::*;

	// ************************************************************
	// registers and bus
	// ************************************************************
	logic [7:0] thr_reg, sw_reg, dg_reg, out_reg, flt_reg, dres_reg;
	logic       wr_stb;
	logic [7:0] reg_addr, wdata, rdata;
	logic       diag_busy;
	logic [1:0] diag_phase;
	logic [1:0] oc_hit;
	amcfm_state_t [1:0] chan_next;

	// the serial port stops in standby and while the supply is below reset level
	wire i2c_en_w = standby_n && !sense.por;

	amcfm_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_i2c (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.enable   (i2c_en_w),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.sda_oe   (sda_oe),
		.wr_stb   (wr_stb),
		.reg_addr (reg_addr),
		.wdata    (wdata),
		.rdata    (rdata)
	);

	// write decode
	wire wr_thr  = wr_stb && (reg_addr == THR_OFS);
	wire wr_sw   = wr_stb && (reg_addr == SWCTL_OFS);
	wire wr_dg   = wr_stb && (reg_addr == DIAGCTL_OFS);
	wire wr_out  = wr_stb && (reg_addr == OUTCTL_OFS);
	wire wr_flt  = wr_stb && (reg_addr == FLT_OFS);
	wire wr_dres = wr_stb && (reg_addr == DRES_OFS);
	// deep sleep, supply collapse or the reset bit bring every register back to default
	wire clr_all = !standby_n || sense.por || (wr_out && wdata[OUT_RESET]);

	// a refused code leaves the previous selection in place
	wire [1:0] thr_code = (wdata[1:0] == CODE_BAD) ? thr_reg[1:0] : wdata[1:0];
	wire [1:0] fs_code  = (wdata[1:0] == CODE_BAD) ? sw_reg[1:0] : wdata[1:0];

	wire [7:0] thr_next  = clr_all ? THR_RST : wr_thr ? ({wdata[7:2], thr_code} & THR_MASK) : thr_reg;
	wire [7:0] sw_next   = clr_all ? SWCTL_RST : wr_sw ? {wdata[7:2], fs_code} : sw_reg;
	wire [7:0] dg_next   = clr_all ? DIAGCTL_RST : wr_dg ? wdata : dg_reg;
	wire [7:0] out_next  = clr_all ? OUTCTL_RST : wr_out ? (wdata & OUTCTL_MASK) : out_reg;

	// ************************************************************
	// fault latching
	// ************************************************************
	// bit order: ots2 ots1 dc2 dc1 oc2 oc1 ov uv; writing a one clears, a new event wins
	wire [7:0] flt_set  = {sense.ots, sense.dc & {2{dg_reg[DG_DCSD]}}, oc_hit, sense.ov, sense.uv};
	wire [7:0] flt_clr  = wr_flt ? wdata : 8'h00;
	wire [7:0] flt_next = clr_all ? 8'h00 : ((flt_reg & ~flt_clr) | flt_set);
	// diagnostic results latch only while the sequencer runs
	wire [7:0] dres_set  = diag_busy ? {4'h0, sense.short, sense.open} : 8'h00;
	wire [7:0] dres_next = clr_all ? 8'h00 : ((dres_reg & ~(wr_dres ? wdata : 8'h00)) | dres_set);

	wire       ots_any  = |flt_reg[7:6];
	wire       supply_f = |flt_reg[1:0];
	// foldback is live, shutdown is the latched copy
	wire [7:0] tstat_w  = {1'b0, flt_reg[7:6], 2'b00, sense.fold, 1'b0};

	// register registers; the register map is only reached through the serial port
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			thr_reg  <= THR_RST;
			sw_reg   <= SWCTL_RST;
			dg_reg   <= DIAGCTL_RST;
			out_reg  <= OUTCTL_RST;
			flt_reg  <= 8'h00;
			dres_reg <= 8'h00;
		end else begin
			thr_reg  <= thr_next;
			sw_reg   <= sw_next;
			dg_reg   <= dg_next;
			out_reg  <= out_next;
			flt_reg  <= flt_next;
			dres_reg <= dres_next;
		end
	end

	// read mux; unmapped offsets read as zero
	assign rdata = (reg_addr == THR_OFS)     ? thr_reg :
	               (reg_addr == TSTAT_OFS)   ? tstat_w :
	               (reg_addr == SWCTL_OFS)   ? sw_reg :
	               (reg_addr == DIAGCTL_OFS) ? dg_reg :
	               (reg_addr == OUTCTL_OFS)  ? out_reg :
	               (reg_addr == FLT_OFS)     ? flt_reg :
	               (reg_addr == DRES_OFS)    ? dres_reg : 8'h00;

	// ************************************************************
	// diagnostics
	// ************************************************************
	wire diag_run = |dg_reg[DG_CH1 +: 2];

	amcfm_diag_seq #(.PHASE_CYC(DIAG_CYCS), .PAUSE_CYC(PAUSE_CYCS)) u_diag (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.run      (diag_run),
		.stretch  (thr_reg[THR_STRETCH]),
		.pause_en (thr_reg[THR_PAUSE]),
		.busy     (diag_busy),
		.phase    (diag_phase)
	);

	// ************************************************************
	// per channel: overcurrent timer and operating state
	// ************************************************************
	for (genvar g = 0; g < 2; g++) begin : g_ch
		logic [31:0] oc_cnt_reg;
		wire         chan_lat = flt_reg[2 + g] || flt_reg[4 + g];
		// limiting that lasts for the whole timer becomes a latched overcurrent
		always_ff @(posedge ref_clk or negedge rstn) begin
			if (!rstn)
				oc_cnt_reg <= 32'd0;
			else if (!sense.cbc[g])
				oc_cnt_reg <= 32'd0;
			else if (oc_cnt_reg != 32'(OC_CYCS))
				oc_cnt_reg <= oc_cnt_reg + 32'd1;
		end
		assign oc_hit[g] = sense.cbc[g] && (oc_cnt_reg == 32'(OC_CYCS - 1));
		// standby beats Hi-Z beats mute beats play
		assign chan_next[g] = (!standby_n || sense.por || ots_any) ? ST_STANDBY :
		                      (supply_f || chan_lat || out_reg[OUT_HIZ1 + g]) ? ST_HIZ :
		                      (out_reg[OUT_MUTE] || !mute_n) ? ST_MUTE : ST_PLAY;
	end

	// ************************************************************
	// pins and outputs
	// ************************************************************
	wire [1:0] clip_cfg = sw_reg[3:2];
	wire       tweet_w  = dg_reg[DG_TWEET] && diag_busy && (|sense.tweeter);
	wire       warn_w   = ((clip_cfg != CLIP_TWEET && clip_cfg != CLIP_THERMAL_WARN_PIN) && (|sense.clip)) ||
	                      ((clip_cfg != CLIP_TWEET && clip_cfg != CLIP_CLIP) && sense.thermal_warning) ||
	                      (sw_reg[SW_FOLDREP] && (|sense.fold)) || tweet_w;
	// any fault that forces Hi-Z or standby pulls the alert line
	wire       fault_w  = sense.por || (|flt_reg);
	// hard mute skips the ramp for reset, overtemperature and channel faults
	wire [1:0] hmute_w  = {2{sense.por || ots_any}} | flt_reg[3:2] | flt_reg[5:4] | flt_set[3:2] | flt_set[5:4];

	wire amcfm_ctl_t ctl_next = '{
		state:      chan_next,
		hard_mute:  hmute_w,
		soft_mute:  !mute_n,
		slow_cm:    thr_reg[THR_SLOWCM],
		dc_thresh:  thr_reg[1:0],
		xtalk:      thr_reg[THR_XTALK],
		fs_sel:     sw_reg[1:0],
		phase_180:  sw_reg[SW_PHASE],
		diag_busy:  diag_busy,
		diag_phase: diag_phase
	};

	// every top output leaves from a flop
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctl          <= '{state: '{ST_STANDBY, ST_STANDBY}, dc_thresh: THR_RST[1:0],
			                  fs_sel: SWCTL_RST[1:0], default: '0};
			fault_oe     <= 1'b0;
			clip_warn_oe <= 1'b0;
		end else begin
			ctl          <= ctl_next;
			fault_oe     <= fault_w;
			clip_warn_oe <= warn_w;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	sequence sw_phase_write;
		wr_sw && wdata[SW_PHASE] && !clr_all;
	endsequence

	thr_code_ok_a: assert property (ctl.dc_thresh != CODE_BAD)
		else $error("threshold code 11 reached the analog side");
	thr_default_a: assert property ($past(!standby_n) |-> thr_reg == THR_RST)
		else $error("threshold register not at default after deep sleep");
	fold_status_a: assert property ((sense.fold == 2'b00 && flt_reg[7:6] == 2'b00) |-> tstat_w == 8'h00)
		else $error("thermal status not zero with nothing affected");
	ots_latch_a: assert property ((sense.ots[0] && !clr_all) |=> tstat_w[5] ##1 (tstat_w[5] || $past(wr_flt || clr_all)))
		else $error("overtemperature shutdown not latched in status");
	fault_pin_a: assert property ((flt_reg != 8'h00) |=> fault_oe)
		else $error("fault alert not driven for a latched fault");
	oc_mute_a: assert property ($rose(flt_reg[2]) |-> ##[0:1] ctl.hard_mute[0] ##1 ctl.state[0] != ST_PLAY)
		else $error("overcurrent did not mute and leave play");
	standby_a: assert property (!standby_n |=> (ctl.state[0] == ST_STANDBY && ctl.state[1] == ST_STANDBY && !sda_oe))
		else $error("deep sleep did not reach standby");
	phase_sel_a: assert property (sw_phase_write ##1 !clr_all |=> ctl.phase_180)
		else $error("phase select did not reach 180 degrees");
	fs_code_ok_a: assert property (ctl.fs_sel != CODE_BAD)
		else $error("invalid switching frequency code applied");
	tweet_warn_a: assert property (tweet_w |=> clip_warn_oe)
		else $error("tweeter found but warning pin idle");
endmodule // amcfm_fault_mgr

// file: sim/amcfm_host.sv
// two-wire bus master model standing in for the host controller
`timescale 1ns/1ps
module amcfm_host (
	input  wire logic ref_clk,
	input  wire logic dev_oe,
	output logic      scl,
	output logic      sda
);
	logic host_oe;
	// wired-and with pull-up, so a released line reads high
	assign sda = !(host_oe || dev_oe);
	initial begin
		scl = 1'b1;
		host_oe = 1'b0;
	end
	// every change lands just after a clock edge
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// start or repeated start: data falls while the clock is high
	task automatic start();
		host_oe = 1'b0;
		tick(5);
		scl = 1'b1;
		tick(5);
		host_oe = 1'b1;
		tick(5);
		scl = 1'b0;
		tick(2);
	endtask
	task automatic stop();
		host_oe = 1'b1;
		tick(5);
		scl = 1'b1;
		tick(5);
		host_oe = 1'b0;
		tick(5);
	endtask
	// eight bits msb first, then the ninth; reads send FF and end in a nack
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
		logic [8:0] v;
		v = {d, a};
		for (int i = 8; i >= 0; i--) begin
			host_oe = !v[i];
			tick(5);
			scl = 1'b1;
			tick(5);
			v[i] = sda;
			scl = 1'b0;
			tick(2);
		end
		r = v[8:1];
		k = v[0];
	endtask
endmodule // amcfm_host

// file: sim/amcfm_fault_mgr_tb.sv
// self-checking bench of the amplifier control and fault manager
`timescale 1ns/1ps
module amcfm_fault_mgr_tb;
	import amcfm_pkg::*;
	localparam int DIAG = 10;
	localparam int PAUSE = 20;
	logic         ref_clk;
	logic         rstn;
	logic         standby_n;
	logic         mute_n;
	logic         scl;
	logic         sda;
	logic         sda_oe;
	logic         fault_oe;
	logic         clip_warn_oe;
	amcfm_sense_t sense;
	amcfm_ctl_t   ctl;
	int           err_count;
	int           n_checks;
	int           n0;
	int           n1;
	logic [7:0]   r;
	logic [7:0]   e;
	logic [7:0]   d;
	logic         k;
	amcfm_fault_mgr #(.PAUSE_CYCS(PAUSE), .DIAG_CYCS(DIAG), .OC_CYCS(8)) uut (
		.ref_clk(ref_clk), .rstn(rstn), .standby_n(standby_n), .mute_n(mute_n),
		.scl_in(scl), .sda_in(sda), .sda_oe(sda_oe), .sense(sense), .ctl(ctl),
		.fault_oe(fault_oe), .clip_warn_oe(clip_warn_oe));
	amcfm_host h (.ref_clk(ref_clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));
	// ************************************************************
	// expectations and bus tasks
	// ************************************************************
	function automatic logic [7:0] thr_exp(input logic [7:0] o, input logic [7:0] v);
		return (v[1:0] == CODE_BAD) ? {v[7:2], o[1:0]} & THR_MASK : v & THR_MASK;
	endfunction
	function automatic logic [7:0] tstat_exp(input amcfm_sense_t s);
		return {1'b0, s.ots, 2'b00, s.fold, 1'b0};
	endfunction
	function automatic logic warn_exp(input logic [1:0] c, input amcfm_sense_t s);
		return (c[0] && |s.clip) || (c[1] && s.thermal_warning);
	endfunction
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] x);
		n_checks++;
		if (s !== x) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic wr(input logic [7:0] o, input logic [7:0] v);
		h.start();
		h.xfer(8'hD8, 1'b1, r, k);
		chk("ack", {7'h00, k}, 8'h00);
		h.xfer(o, 1'b1, r, k);
		h.xfer(v, 1'b1, r, k);
		h.stop();
	endtask
	task automatic rd(input logic [7:0] o, input logic [7:0] x, input string nm);
		h.start();
		h.xfer(8'hD8, 1'b1, r, k);
		h.xfer(o, 1'b1, r, k);
		h.start();
		h.xfer(8'hD9, 1'b1, r, k);
		h.xfer(8'hFF, 1'b1, r, k);
		h.stop();
		chk(nm, r, x);
	endtask
	// busy length of one diagnostic run; the bound guards against a stuck run
	task automatic diag(input logic [1:0] sp, output int n);
		wr(THR_OFS, {3'b000, sp, 3'b001});
		wr(DIAGCTL_OFS, 8'h52);
		n = 0;
		while (ctl.diag_busy === 1'b1 && n < 500) begin
			h.tick(1);
			n++;
		end
		if (n == 500) begin
			err_count++;
			end_sim();
		end
		wr(DIAGCTL_OFS, DIAGCTL_RST);
	endtask
	// latched fault: pin and state, cause readable, cleared by write-one
	task automatic flt(input logic [7:0] fr, input int c, input amcfm_state_t st);
		h.tick(3);
		chk("fault pin", {7'h00, fault_oe}, 8'h01);
		chk("state", 8'(ctl.state[c]), 8'(st));
		sense = '0;
		rd(FLT_OFS, fr, "fault cause");
		wr(FLT_OFS, fr);
		rd(FLT_OFS, 8'h00, "fault clear");
		chk("fault pin off", {7'h00, fault_oe}, 8'h00);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// free-running clock, 20 ns period
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = !ref_clk;
	end
	// main sequence
	initial begin
		rstn = 1'b0;
		standby_n = 1'b1;
		mute_n = 1'b1;
		sense = '0;
		err_count = 0;
		n_checks = 0;
		void'($urandom(80304));
		repeat (6) @(posedge ref_clk);
		#1;
		rstn = 1'b1;
		h.tick(3);
		rd(THR_OFS, THR_RST, "thr reset");
		rd(TSTAT_OFS, 8'h00, "status reset");
		chk("fs reset", 8'(ctl.fs_sel), 8'h01);
		chk("reset hiz", 8'(ctl.state[1]), 8'(ST_HIZ));
		$display("test reset done");
		e = THR_RST;
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom);
			d[1:0] = 2'(i);
			wr(THR_OFS, d);
			e = thr_exp(e, d);
			rd(THR_OFS, e, "thr");
			chk("thr code", 8'(ctl.dc_thresh), {6'h00, e[1:0]});
			chk("xtalk slowcm", {6'h00, ctl.xtalk, ctl.slow_cm}, {6'h00, e[2], e[7]});
		end
		$display("test threshold done");
		diag(2'b00, n0);
		diag(2'b10, n1);
		chk("stretch", 8'(n1 - n0), 8'(6 * DIAG));
		diag(2'b01, n1);
		chk("pause", 8'(n1 - n0), 8'(3 * PAUSE));
		sense.tweeter = 2'($urandom) | 2'b01;
		sense.open = 2'($urandom);
		sense.short = 2'($urandom);
		wr(DIAGCTL_OFS, 8'h72);
		h.tick(3);
		chk("tweeter warn", {7'h00, clip_warn_oe}, 8'h01);
		rd(DRES_OFS, {4'h0, sense.short, sense.open}, "diag result");
		sense = '0;
		wr(DIAGCTL_OFS, DIAGCTL_RST);
		wr(DRES_OFS, 8'hFF);
		rd(DRES_OFS, 8'h00, "diag clear");
		$display("test diag done");
		for (int i = 0; i < 3; i++) begin
			sense.fold = 2'($urandom);
			h.tick(3);
			rd(TSTAT_OFS, tstat_exp(sense), "foldback");
		end
		sense = '0;
		wr(OUTCTL_OFS, 8'h00);
		chk("play", 8'(ctl.state[0]), 8'(ST_PLAY));
		wr(OUTCTL_OFS, 8'h10);
		chk("host mute", 8'(ctl.state[0]), 8'(ST_MUTE));
		wr(OUTCTL_OFS, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(SWCTL_OFS, {2'b00, 1'(i), 1'b0, 2'(i), 2'(i)});
			chk("fs", 8'(ctl.fs_sel), (i == 3) ? 8'h02 : 8'(i));
			chk("phase", {7'h00, ctl.phase_180}, 8'(i & 1));
			repeat (3) begin
				sense.thermal_warning = 1'($urandom);
				sense.clip = 2'($urandom);
				h.tick(3);
				chk("warn pin", {7'h00, clip_warn_oe}, {7'h00, warn_exp(2'(i), sense)});
				chk("warn no fault", {7'h00, fault_oe}, 8'h00);
			end
		end
		sense = '0;
		$display("test warn done");
		mute_n = 1'b0;
		h.tick(3);
		chk("soft mute", {7'h00, ctl.soft_mute}, 8'h01);
		chk("mute", 8'(ctl.state[1]), 8'(ST_MUTE));
		mute_n = 1'b1;
		sense.cbc = 2'b01;
		h.tick(10);
		flt(8'h04, 0, ST_HIZ);
		{sense.ov, sense.uv} = 2'($urandom % 3) + 2'd1;
		d = {6'h00, sense.ov, sense.uv};
		h.tick(1);
		sense = '0;
		flt(d, 1, ST_HIZ);
		n0 = $urandom % 2;
		sense.dc = 2'(1 << n0);
		flt({2'b00, sense.dc, 4'h0}, n0, ST_HIZ);
		sense.ots = 2'($urandom) | 2'b01;
		h.tick(3);
		rd(TSTAT_OFS, tstat_exp(sense), "ot shutdown");
		flt({sense.ots, 6'h00}, 1, ST_STANDBY);
		sense.por = 1'b1;
		h.tick(3);
		chk("por pin", {7'h00, fault_oe}, 8'h01);
		chk("por state", 8'(ctl.state[0]), 8'(ST_STANDBY));
		chk("por mute", 8'(ctl.hard_mute), 8'h03);
		h.start();
		h.xfer(8'hD8, 1'b1, r, k);
		h.stop();
		chk("no ack por", {7'h00, k}, 8'h01);
		sense.por = 1'b0;
		h.tick(3);
		chk("por clears", {7'h00, fault_oe}, 8'h00);
		$display("test faults done");
		standby_n = 1'b0;
		h.tick(3);
		chk("standby", 8'(ctl.state[0]), 8'(ST_STANDBY));
		h.start();
		h.xfer(8'hD8, 1'b1, r, k);
		h.stop();
		chk("no ack asleep", {7'h00, k}, 8'h01);
		standby_n = 1'b1;
		h.tick(3);
		rd(THR_OFS, THR_RST, "thr default");
		rd(SWCTL_OFS, SWCTL_RST, "swctl default");
		wr(THR_OFS, 8'h84);
		wr(OUTCTL_OFS, 8'h80);
		rd(THR_OFS, THR_RST, "soft reset");
		$display("test standby done");
		end_sim();
	end
endmodule // amcfm_fault_mgr_tb
